/* File: include/spcs_params.svh */
// Purpose: constants of the spi control and status block
// Assumes: 12-bit byte addresses, 8-bit registers
// Notes: included by bare name
// How it works
// - interrupt_enable low blocks the interrupt output; high forwards pending requests.
// - writing 1 to force_interrupt sets interrupt_pending; writing 0 does nothing.
// - writing 1 to interrupt_pending also clears force_interrupt.
// - timer_irq_enable acts only while disabled, running the baud generator as timer.
// - open_drain_enable makes all four spi pins open-drain.
// - master_select picks slave or master; block_enable disables or enables.
// - while disabled every status bit holds its reset value.
// - the four sticky flags read back and clear on a written 1 or while the block is disabled.
// - timer time-out raises the interrupt but never sets interrupt_pending.
// - overrun_flag reads 1 once an overrun was seen.
// - mode_fault_flag reads 1 once a multimaster collision was seen.
// - slave select rising mid character sets slave_abort_flag and interrupt_pending.
// - transfer_active is read-only, 1 while a transfer is in progress.
// - slave_select_level reads the slave-select input level in slave mode.
// - control register resets to all zero.
// - data write during a transfer is dropped and sets overrun_flag.
// - enabled master with select input driven low sets mode_fault_flag, unless ss_out_en is set.
`ifndef SPCS_PARAMS_SVH
`define SPCS_PARAMS_SVH

`define SPCS_ADDR_DATA 12'hf60
`define SPCS_ADDR_CTL 12'hf61
`define SPCS_ADDR_STAT 12'hf62
`define SPCS_ADDR_MODE 12'hf63
`define SPCS_ADDR_BRG_HI 12'hf66
`define SPCS_ADDR_BRG_LO 12'hf67

`define SPCS_CTL_RST 8'h00
`define SPCS_STAT_RST 8'h01
`define SPCS_MODE_RST 8'h00
`define SPCS_BRG_RST 8'hff
`define SPCS_DATA_RST 8'h00

`define SPCS_STAT_PEND 7
`define SPCS_STAT_OVR 6
`define SPCS_STAT_COL 5
`define SPCS_STAT_ABT 4
`define SPCS_MODE_MASK 8'h3f

`endif

/* File: include/spcs_pkg.sv */
// Purpose: types of the spi control and status block
// Assumes: nothing
// Notes: field order follows the register bit order, msb first
package spcs_pkg;
	typedef struct packed {
		logic irq_en;
		logic force_irq;
		logic timer_en;
		logic edge_sel;
		logic idle_lvl;
		logic open_drain;
		logic master;
		logic enable;
	} spcs_ctl_s;

	typedef struct packed {
		logic [1:0] rsvd;
		logic diag;
		logic [2:0] char_len;
		logic ss_out_en;
		logic ss_out_val;
	} spcs_mode_s;

	typedef struct packed {
		logic o;
		logic oe;
	} spcs_pin_s;

	typedef enum logic {
		SPCS_IDLE,
		SPCS_XFER
	} spcs_state_e;
endpackage

/* File: design/spcs_sync.sv */
// Purpose: two-flop synchroniser for the four spi pin inputs
// Assumes: inputs asynchronous to i_core_clk
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module spcs_sync (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [3:0] i_async,
	output logic [3:0] o_sync
);
	logic [3:0] meta;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			meta <= 4'h4;
			o_sync <= 4'h4;
		end else if (i_ce) begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule

/* File: design/spcs_top.sv */
// Purpose: spi port control, status and a small shift engine
// Assumes: registers reached over a plain strobe port, pins sampled by i_core_clk
// Notes: pin order into the synchroniser is {sck, ss_n, miso, mosi}
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "spcs_params.svh"
module spcs_top (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rd_data,
	output logic o_irq,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	input wire logic i_ss_n,
	output logic o_ss_n,
	output logic o_ss_n_oe,
	input wire logic i_miso,
	output logic o_miso,
	output logic o_miso_oe,
	input wire logic i_mosi,
	output logic o_mosi,
	output logic o_mosi_oe
);
	import spcs_pkg::*;

	function automatic logic [3:0] char_bits(input logic [2:0] code);
		char_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
	endfunction

	// open drain only ever pulls low
	function automatic spcs_pin_s pin_drive(input logic od, input logic drv, input logic val);
		spcs_pin_s p;
		p.o = od ? 1'b0 : val;
		p.oe = od ? (drv & ~val) : drv;
		pin_drive = p;
	endfunction

	spcs_ctl_s ctl;
	spcs_mode_s mode;
	logic [7:0] brg_hi;
	logic [7:0] brg_lo;
	logic irq_pend;
	logic overrun_flag;
	logic col;
	logic slave_abort_flag;
	logic [7:0] shreg;
	logic rx_bit;
	logic have_bit;
	logic [3:0] bit_cnt;
	spcs_state_e state;
	logic sck_drv;
	logic [15:0] brg_cnt;
	logic [3:0] pins_s;
	logic sck_prev;
	logic ss_prev;

	logic sck_s;
	logic ss_s;
	logic miso_s;
	logic mosi_s;
	logic wr_data;
	logic wr_ctl;
	logic wr_stat;
	logic wr_mode;
	logic [7:0] clr;
	logic busy;
	logic is_master;
	logic is_slave;
	logic [15:0] brg_reload;
	logic brg_run;
	logic brg_tick;
	logic timer_pulse;
	logic edge_ev;
	logic leading;
	logic is_sample;
	logic [3:0] len;
	logic [3:0] next_cnt;
	logic in_bit;
	logic done_ev;
	logic abort_ev;
	logic ss_fall;
	logic start_ev;
	logic set_pend;
	logic [7:0] stat_rd;
	logic [7:0] next_rd;
	spcs_pin_s sck_pin;
	spcs_pin_s ss_pin;
	spcs_pin_s miso_pin;
	spcs_pin_s mosi_pin;

	spcs_sync u_sync (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_async({i_sck, i_ss_n, i_miso, i_mosi}),
		.o_sync(pins_s)
	);

	assign sck_s = pins_s[3];
	assign ss_s = pins_s[2];
	assign miso_s = pins_s[1];
	assign mosi_s = pins_s[0];

	assign wr_data = i_wr & (i_addr == `SPCS_ADDR_DATA);
	assign wr_ctl = i_wr & (i_addr == `SPCS_ADDR_CTL);
	assign wr_stat = i_wr & (i_addr == `SPCS_ADDR_STAT);
	assign wr_mode = i_wr & (i_addr == `SPCS_ADDR_MODE);
	assign clr = wr_stat ? i_wr_data : 8'h00;

	assign busy = (state == SPCS_XFER);
	assign is_master = ctl.enable & ctl.master;
	assign is_slave = ctl.enable & ~ctl.master;
	assign len = char_bits(mode.char_len);
	assign next_cnt = bit_cnt + 4'h1;
	assign in_bit = ctl.master ? miso_s : mosi_s;

	// baud generator: master half period, or time-out timer while disabled
	assign brg_reload = {brg_hi, brg_lo};
	assign brg_run = (is_master & busy) | (~ctl.enable & ctl.timer_en);
	assign brg_tick = brg_run & (brg_cnt == 16'h0001);
	assign timer_pulse = brg_tick & ~ctl.enable & ctl.timer_en;

	// serial clock edges, own in master mode, sampled in slave mode
	always_comb begin
		edge_ev = 1'b0;
		leading = 1'b0;
		if (is_master) begin
			edge_ev = busy & brg_tick;
			leading = (sck_drv == ctl.idle_lvl);
		end else if (is_slave) begin
			edge_ev = ~ss_s & ~ss_prev & (sck_s != sck_prev);
			leading = (sck_prev == ctl.idle_lvl);
		end
	end

	assign is_sample = leading ^ ctl.edge_sel;
	assign done_ev = edge_ev & ((is_sample & ctl.edge_sel & (next_cnt == len)) |
		(~is_sample & ~ctl.edge_sel & have_bit & (bit_cnt == len)));
	assign abort_ev = is_slave & busy & ss_s & ~ss_prev;
	assign ss_fall = is_slave & ~ss_s & ss_prev;
	assign start_ev = is_master & wr_data & ~busy;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sck_prev <= 1'b0;
			ss_prev <= 1'b1;
		end else if (i_ce) begin
			sck_prev <= sck_s;
			ss_prev <= ss_s;
		end
	end

	// control register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl <= `SPCS_CTL_RST;
		end else if (i_ce) begin
			if (wr_ctl) begin
				ctl <= i_wr_data;
				ctl.force_irq <= ctl.force_irq | i_wr_data[6];
			end else if (clr[`SPCS_STAT_PEND]) begin
				ctl.force_irq <= 1'b0;
			end
		end
	end

	// mode and baud registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mode <= `SPCS_MODE_RST;
			brg_hi <= `SPCS_BRG_RST;
			brg_lo <= `SPCS_BRG_RST;
		end else if (i_ce) begin
			if (wr_mode) begin
				mode <= i_wr_data & `SPCS_MODE_MASK;
			end
			if (i_wr & (i_addr == `SPCS_ADDR_BRG_HI)) begin
				brg_hi <= i_wr_data;
			end
			if (i_wr & (i_addr == `SPCS_ADDR_BRG_LO)) begin
				brg_lo <= i_wr_data;
			end
		end
	end

	// down counter, a reload of zero gives 65536 cycles
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			brg_cnt <= 16'h0000;
		end else if (i_ce) begin
			if (!brg_run || brg_tick) begin
				brg_cnt <= brg_reload;
			end else begin
				brg_cnt <= brg_cnt - 16'h0001;
			end
		end
	end

	// transfer state
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= SPCS_IDLE;
		end else if (i_ce) begin
			if (!ctl.enable || done_ev || abort_ev) begin
				state <= SPCS_IDLE;
			end else if (start_ev || (is_slave && edge_ev)) begin
				state <= SPCS_XFER;
			end
		end
	end

	// master clock output returns to the idle level between transfers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sck_drv <= 1'b0;
		end else if (i_ce) begin
			if (!busy || !is_master) begin
				sck_drv <= ctl.idle_lvl;
			end else if (edge_ev) begin
				sck_drv <= ~sck_drv;
			end
		end
	end

	// bit counting and sampling
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt <= 4'h0;
			have_bit <= 1'b0;
			rx_bit <= 1'b0;
		end else if (i_ce) begin
			if (!ctl.enable || done_ev || abort_ev || start_ev || ss_fall) begin
				bit_cnt <= 4'h0;
				have_bit <= 1'b0;
			end else if (edge_ev && is_sample) begin
				bit_cnt <= next_cnt;
				have_bit <= 1'b1;
				rx_bit <= in_bit;
			end else if (edge_ev) begin
				have_bit <= 1'b0;
			end
		end
	end

	// shift register, loaded only while no transfer runs
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			shreg <= `SPCS_DATA_RST;
		end else if (i_ce) begin
			if (wr_data && !busy) begin
				shreg <= i_wr_data;
			end else if (edge_ev && !is_sample && have_bit) begin
				shreg <= {shreg[6:0], rx_bit};
			end else if (edge_ev && is_sample && done_ev) begin
				shreg <= {shreg[6:0], in_bit};
			end
		end
	end

	// force_interrupt only counts while it is not being cleared
	assign set_pend = (ctl.force_irq & ~clr[`SPCS_STAT_PEND]) | done_ev | abort_ev;

	// sticky flags, set wins over a write-1 clear
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_pend <= 1'b0;
			overrun_flag <= 1'b0;
			col <= 1'b0;
			slave_abort_flag <= 1'b0;
		end else if (i_ce) begin
			if (!ctl.enable) begin
				irq_pend <= 1'b0;
				overrun_flag <= 1'b0;
				col <= 1'b0;
				slave_abort_flag <= 1'b0;
			end else begin
				irq_pend <= set_pend | (irq_pend & ~clr[`SPCS_STAT_PEND]);
				overrun_flag <= (wr_data & busy) | (overrun_flag & ~clr[`SPCS_STAT_OVR]);
				col <= (is_master & ~mode.ss_out_en & ~ss_s) |
					(col & ~clr[`SPCS_STAT_COL]);
				slave_abort_flag <= abort_ev | (slave_abort_flag & ~clr[`SPCS_STAT_ABT]);
			end
		end
	end

	// interrupt line, timer time-outs bypass the pending flag
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq <= ctl.irq_en & (irq_pend | timer_pulse);
		end
	end

	assign stat_rd = {irq_pend, overrun_flag, col, slave_abort_flag, 2'b00, busy,
		ctl.enable ? ss_s : 1'b1};

	always_comb begin
		case (i_addr)
			`SPCS_ADDR_DATA: next_rd = shreg;
			`SPCS_ADDR_CTL: next_rd = ctl;
			`SPCS_ADDR_STAT: next_rd = stat_rd;
			`SPCS_ADDR_MODE: next_rd = mode;
			`SPCS_ADDR_BRG_HI: next_rd = mode.diag ? brg_cnt[15:8] : brg_hi;
			`SPCS_ADDR_BRG_LO: next_rd = mode.diag ? brg_cnt[7:0] : brg_lo;
			default: next_rd = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= 8'h00;
		end else if (i_ce) begin
			o_rd_data <= i_rd ? next_rd : 8'h00;
		end
	end

	// pins
	assign sck_pin = pin_drive(ctl.open_drain, is_master, sck_drv);
	assign ss_pin = pin_drive(ctl.open_drain, is_master & mode.ss_out_en,
		mode.ss_out_val);
	assign mosi_pin = pin_drive(ctl.open_drain, is_master, shreg[7]);
	assign miso_pin = pin_drive(ctl.open_drain, is_slave & ~ss_s, shreg[7]);

	assign o_sck = sck_pin.o;
	assign o_sck_oe = sck_pin.oe;
	assign o_ss_n = ss_pin.o;
	assign o_ss_n_oe = ss_pin.oe;
	assign o_mosi = mosi_pin.o;
	assign o_mosi_oe = mosi_pin.oe;
	assign o_miso = miso_pin.o;
	assign o_miso_oe = miso_pin.oe;
endmodule

/* File: verification/spcs_top_asserts.sv */
// Purpose: port checks of the spi control and status block
// Assumes: mirror follows i_ce like the design
// Notes: ctl mirrors the control register from bus writes
`timescale 1ns/1ps
module spcs_top_asserts (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rd_data,
	input wire logic o_irq,
	input wire logic o_sck,
	input wire logic o_sck_oe,
	input wire logic o_mosi,
	input wire logic o_mosi_oe
);
	logic [7:0] ctl;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl <= 8'h00;
		end else if (i_ce) begin
			if (i_wr && i_addr == 12'hf61) begin
				ctl <= i_wr_data | (ctl & 8'h40);
			end else if (i_wr && i_addr == 12'hf62 && i_wr_data[7]) begin
				ctl[6] <= 1'b0;
			end
		end
	end
	AST_IRQ_OFF: assert property (!ctl[7] |=> !o_irq)
		else $error("irq while masked");
	AST_FORCE: assert property (i_wr && i_addr == 12'hf61 && i_wr_data[7]
		&& i_wr_data[6] && i_wr_data[0] |-> ##[1:4] o_irq) else $error("force no irq");
	AST_CTL_RD: assert property (i_rd && i_addr == 12'hf61
		|=> o_rd_data == $past(ctl)) else $error("control readback");
	AST_STAT_OFF: assert property (i_rd && i_addr == 12'hf62 && !ctl[0]
		|=> o_rd_data == 8'h01) else $error("status while disabled");
	AST_RSVD: assert property (i_rd && i_addr == 12'hf62
		|=> o_rd_data[3:2] == 2'b00) else $error("reserved status bits");
	AST_SCK_OE: assert property (o_sck_oe |-> ctl[1:0] == 2'b11)
		else $error("sck driven when not master");
	AST_OD: assert property (ctl[2] |-> !(o_sck_oe && o_sck) && !(o_mosi_oe && o_mosi))
		else $error("open drain drove high");
	AST_PP: assert property (ctl[2:0] == 3'b011 |-> o_sck_oe && o_mosi_oe)
		else $error("push pull not driven");
endmodule
bind spcs_top spcs_top_asserts i_spcs_top_asserts (.i_core_clk, .i_rst, .i_ce, .i_addr, .i_wr_data,
	.i_wr, .i_rd, .o_rd_data, .o_irq, .o_sck, .o_sck_oe, .o_mosi, .o_mosi_oe);

/* File: verification/spcs_peer.sv */
// Purpose: far spi party, slave on the wire clock or master at 125 ns
// Assumes: master role idles sck low, samples on rising edges
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
module spcs_peer (
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_miso,
	input wire logic i_phase,
	output logic o_sck,
	output logic o_ss_n,
	output logic o_mosi,
	output logic o_miso
);
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	logic on = 1'b0;
	// mosi as it stood just before an sck edge made on the same clock edge
	logic mosi_q = 1'b0;
	int k = 0;
	int e = 0;
	initial begin
		o_sck = 1'b0;
		o_ss_n = 1'b1;
		o_mosi = 1'b0;
		o_miso = 1'b0;
	end
	always @(i_mosi) begin
		mosi_q <= #1 i_mosi;
	end
	always @(i_sck) begin
		if (on) begin
			if (e[0] == i_phase) begin
				rx = {rx[6:0], mosi_q};
			end else begin
				if (k < 8) o_miso = tx[7 - k];
				k++;
			end
			e++;
		end
	end
	task automatic arm(input logic [7:0] d);
		tx = d;
		k = i_phase ? 0 : 1;
		e = 0;
		o_miso = d[7];
		on = 1'b1;
	endtask
	task automatic disarm();
		on = 1'b0;
		o_miso = ~o_miso;
	endtask
	task automatic sel(input logic lvl);
		o_ss_n = lvl;
		#200;
	endtask
	task automatic bits(input logic [7:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			o_mosi = d[7 - i];
			#62.5 o_sck = 1'b1;
			rx = {rx[6:0], i_miso};
			#62.5 o_sck = 1'b0;
		end
		o_mosi = ~o_mosi;
	endtask
endmodule

/* File: verification/spi_control_and_status_test.sv */
// Purpose: self-checking bench of the spi control and status block
// Assumes: peer model on the pins, i_ce dropped once to check the freeze
// Notes: expectations come from the register map held here
`timescale 1ns/1ps
module spi_control_and_status_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic phase = 1'b0;
	logic ce = 1'b1;
	logic [7:0] rdat, d, e, v;
	logic irq, sck, sck_oe, ss_n, ss_n_oe, miso, miso_oe, mosi, mosi_oe;
	logic p_sck, p_ss_n, p_mosi, p_miso;
	logic [31:0] seed = 32'h000069a8;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	int cnt;
	wire sck_w = sck_oe ? sck : p_sck;
	wire ss_w = ss_n_oe ? ss_n : p_ss_n;
	wire miso_w = miso_oe ? miso : p_miso;
	wire mosi_w = mosi_oe ? mosi : p_mosi;
	spcs_top i_spcs_top (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
		.i_wr_data(wd), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .o_irq(irq), .i_sck(sck_w),
		.o_sck(sck), .o_sck_oe(sck_oe), .i_ss_n(ss_w), .o_ss_n(ss_n), .o_ss_n_oe(ss_n_oe),
		.i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe), .i_mosi(mosi_w), .o_mosi(mosi),
		.o_mosi_oe(mosi_oe));
	spcs_peer i_spcs_peer (.i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_phase(phase),
		.o_sck(p_sck), .o_ss_n(p_ss_n), .o_mosi(p_mosi), .o_miso(p_miso));
	initial begin
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wd <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x,
		input string s);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(s, rdat & m, x);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(12'hf61, 8'hff, 8'h00, "ctl reset");
		rc(12'hf62, 8'hff, 8'h01, "stat reset");
		rc(12'hf68, 8'hff, 8'h00, "unmapped");
		wr_reg(12'hf66, 8'h00);
		wr_reg(12'hf67, 8'h06);
		wr_reg(12'hf61, 8'ha0);
		repeat (12) @(posedge clk);
		cnt = 0;
		repeat (60) @(posedge clk) cnt += irq;
		chk("timer", 8'(cnt), 8'h0a);
		rc(12'hf62, 8'hff, 8'h01, "timer pend");
		wr_reg(12'hf61, 8'ha1);
		// let a time-out launched by the old setting drain
		repeat (2) @(posedge clk);
		cnt = 0;
		repeat (40) @(posedge clk) cnt += irq;
		chk("timer off", 8'(cnt), 8'h00);
		for (int i = 0; i < 3; i++) begin
			v = rnd() & 8'hbe;
			wr_reg(12'hf61, v);
			rc(12'hf61, 8'hff, v, "ctl rw");
		end
		// a write while the clock enable is low must be lost
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(12'hf61, 8'h55);
		ce <= 1'b1;
		rc(12'hf61, 8'hff, v, "ce freeze");
		for (int i = 0; i < 3; i++) begin
			v = (8'h07 | (i[0] ? 8'h08 : 8'h00)) ^ (i[1] ? 8'h0c : 8'h00);
			wr_reg(12'hf61, v);
			repeat (2) @(posedge clk);
			chk("sck pin", {6'h00, sck_oe, sck}, i == 1 ? 8'h00 : 8'h02 + i[1]);
		end
		wr_reg(12'hf61, 8'hc1);
		repeat (3) @(posedge clk);
		chk("force irq", {7'h00, irq}, 8'h01);
		rc(12'hf62, 8'hff, 8'h81, "force pend");
		wr_reg(12'hf62, 8'h80);
		rc(12'hf61, 8'hff, 8'h81, "force clr");
		rc(12'hf62, 8'hff, 8'h01, "pend clr");
		wr_reg(12'hf61, 8'h41);
		repeat (3) @(posedge clk);
		chk("irq mask", {7'h00, irq}, 8'h00);
		wr_reg(12'hf62, 8'h80);
		wr_reg(12'hf67, 8'h08);
		for (int ph = 0; ph < 2; ph++) begin
			phase = ph[0];
			wr_reg(12'hf61, ph[0] ? 8'h1b : 8'h03);
			// idle level change moves sck, keep it out of the peer's count
			repeat (2) @(posedge clk);
			d = rnd();
			e = rnd();
			i_spcs_peer.arm(e);
			wr_reg(12'hf60, d);
			rc(12'hf62, 8'hfe, 8'h02, "busy");
			wr_reg(12'hf60, d ^ 8'h5a);
			repeat (140) @(posedge clk);
			rc(12'hf62, 8'hfe, 8'hc0, "done");
			rc(12'hf60, 8'hff, e, "rx");
			chk("peer rx", i_spcs_peer.rx, d);
			chk("sck idle", {7'h00, sck}, {7'h00, ph[0]});
			i_spcs_peer.disarm();
			wr_reg(12'hf62, 8'hc0);
		end
		i_spcs_peer.sel(1'b0);
		rc(12'hf62, 8'h20, 8'h20, "fault");
		i_spcs_peer.sel(1'b1);
		wr_reg(12'hf62, 8'h20);
		rc(12'hf62, 8'hf0, 8'h00, "fault clr");
		wr_reg(12'hf63, 8'hff);
		rc(12'hf63, 8'hff, 8'h3f, "mode rw");
		chk("ss high", {6'h00, ss_n_oe, ss_n}, 8'h03);
		wr_reg(12'hf63, 8'h02);
		repeat (4) @(posedge clk);
		rc(12'hf62, 8'h20, 8'h00, "ss out no fault");
		chk("ss low", {6'h00, ss_n_oe, ss_n}, 8'h02);
		wr_reg(12'hf63, 8'h03);
		wr_reg(12'hf61, 8'h07);
		rc(12'hf62, 8'h20, 8'h00, "od no fault");
		chk("ss od", {6'h00, ss_n_oe, ss_n}, 8'h00);
		// one-bit character as master
		wr_reg(12'hf63, 8'h04);
		wr_reg(12'hf61, 8'h03);
		phase = 1'b0;
		repeat (2) @(posedge clk);
		i_spcs_peer.arm(e);
		wr_reg(12'hf60, d);
		repeat (30) @(posedge clk);
		rc(12'hf62, 8'hfe, 8'h80, "short done");
		rc(12'hf60, 8'hff, {d[6:0], e[7]}, "short rx");
		chk("short tx", {7'h00, i_spcs_peer.rx[0]}, {7'h00, d[7]});
		i_spcs_peer.disarm();
		wr_reg(12'hf63, 8'h00);
		wr_reg(12'hf62, 8'he0);
		wr_reg(12'hf61, 8'h01);
		phase = 1'b0;
		wr_reg(12'hf60, d);
		i_spcs_peer.sel(1'b0);
		i_spcs_peer.bits(e, 8);
		repeat (6) @(posedge clk);
		rc(12'hf62, 8'hff, 8'h80, "slave done");
		i_spcs_peer.sel(1'b1);
		rc(12'hf60, 8'hff, e, "slave rx");
		chk("slave tx", i_spcs_peer.rx, d);
		wr_reg(12'hf62, 8'h80);
		i_spcs_peer.sel(1'b0);
		i_spcs_peer.bits(e, 3);
		rc(12'hf62, 8'hff, 8'h02, "slave busy");
		i_spcs_peer.sel(1'b1);
		rc(12'hf62, 8'hff, 8'h91, "abort");
		wr_reg(12'hf61, 8'h00);
		rc(12'hf62, 8'hff, 8'h01, "disabled");
		stop_test();
	end
endmodule
